// [hdl/sdm_pkg.sv]
// Shared constants for the mode register block and its controller.
// Assumes one 100 MHz clock shared by both ends.
package sdm_pkg;
   localparam int COL_W = 10;
   localparam logic [7:0] MA_BURST = 8'h01;
   localparam logic [7:0] MA_LAT = 8'h02;
   localparam logic [7:0] MA_DRIVE = 8'h03;
   localparam logic [7:0] MA_TEMP = 8'h04;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_16 = 3'h4;
   localparam logic [7:0] BURST_RST = 8'h22;
   localparam logic [3:0] LAT_RST = 4'h1;
   localparam logic [3:0] DRIVE_RST = 4'h2;
   localparam logic [2:0] RATE_RST = 3'h3;
   localparam logic [2:0] RATE_RSVD = 3'h4;
   localparam logic [2:0] RATE_DERATE = 3'h6;
   localparam int FLAG_BIT = 7;
   localparam logic [7:0] LOW_MASK = 8'h0f;
   // Columns where a no-wrap burst would cross a boundary
   localparam logic [8:0] NW_BAD_COL = 9'h1fe;
   // Software register byte offsets
   localparam logic [7:0] OFS_MRW = 8'h00;
   localparam logic [7:0] OFS_MRR = 8'h04;
   localparam logic [7:0] OFS_BURST = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam int ST_BUSY = 0;
   localparam int ST_ERR = 1;
   localparam int ST_DERATE = 2;
   localparam int ST_RVALID = 3;
   localparam int BURST_WR_BIT = 16;
   // Derating time and its cycle count, rounded up
   localparam real DERATE_NS = 1.875;
   localparam real CLK_NS = 10.0;
   localparam int DERATE_CYC_I = int'((DERATE_NS + CLK_NS - 0.001) / CLK_NS);
   localparam logic [3:0] DERATE_CYC = 4'(DERATE_CYC_I < 1 ? 1 : DERATE_CYC_I);
endpackage

// [hdl/sdm_link_if.sv]
// Link between the memory controller and the mode register logic.
// Both ends run on the same clock; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface sdm_link_if;
   import sdm_pkg::*;
   logic mr_wr;
   logic mr_rd;
   logic [7:0] mr_addr;
   logic [7:0] mr_wdata;
   logic [7:0] mr_rdata;
   logic mr_rvalid;
   logic burst_start;
   logic burst_write;
   logic [COL_W-1:1] burst_col;
   logic beat_valid;
   logic beat_last;
   logic beat_write;
   logic [COL_W-1:0] beat_col;
   modport device (
      input mr_wr, mr_rd, mr_addr, mr_wdata, burst_start, burst_write,
      burst_col,
      output mr_rdata, mr_rvalid, beat_valid, beat_last, beat_write, beat_col
   );
   modport ctrl (
      output mr_wr, mr_rd, mr_addr, mr_wdata, burst_start, burst_write,
      burst_col,
      input mr_rdata, mr_rvalid, beat_valid, beat_last, beat_write, beat_col
   );
endinterface

// [hdl/sdm_device.sv]
// Mode register logic of the memory: burst order, latency, drive, temp.
// Assumes the controller keeps its side of the link rules.
`timescale 1ns/1ps
module sdm_device
   import sdm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   sdm_link_if.device lnk,
   input wire logic [2:0] temp_rate_in,
   output logic [3:0] read_latency,
   output logic [2:0] write_latency,
   output logic [3:0] drive_strength_code
);
   // Latency decode: {legal, read latency, write latency}
   function automatic logic [7:0] lat_dec(input logic [3:0] c);
      case (c)
         4'h1: lat_dec = 8'h99;
         4'h2: lat_dec = 8'ha2;
         4'h3: lat_dec = 8'hb2;
         4'h4: lat_dec = 8'hc3;
         4'h5: lat_dec = 8'hd4;
         4'h6: lat_dec = 8'he4;
         default: lat_dec = 8'h00;
      endcase
   endfunction

   logic [2:0] burst_length_ff;
   logic burst_type_ff;
   logic wrap_control_ff;
   logic [7:0] burst_reg_ff;
   logic [3:0] lat_code_ff;
   logic [3:0] read_latency_ff;
   logic [2:0] write_latency_ff;
   logic [3:0] drive_ff;
   logic [2:0] rate_s1_ff;
   logic [2:0] rate_s2_ff;
   logic [2:0] rate_ff;
   logic flag_ff;
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic run_ff;
   logic [3:0] idx_ff;
   logic [3:0] mask_ff;
   logic mode_int_ff;
   logic mode_nw_ff;
   logic [COL_W-1:0] start_ff;
   logic beat_valid_ff;
   logic beat_last_ff;
   logic beat_write_ff;
   logic [COL_W-1:0] beat_col_ff;
   logic [COL_W-1:0] start_col;
   logic [3:0] len_mask;
   logic [3:0] cur_idx;
   logic [COL_W-1:0] cur_start;
   logic [3:0] cur_mask;
   logic cur_int;
   logic cur_nw;
   logic [COL_W-1:0] lo_mask;
   logic [COL_W-1:0] wide_idx;
   logic [COL_W-1:0] nxt_col;
   logic [7:0] lat_word;
   logic [7:0] lat_new;
   logic wr_burst;
   logic wr_lat;
   logic wr_drive;
   logic rd_temp;
   logic rate_chg;
   logic [3:0] wd_low;

   assign start_col = {lnk.burst_col, 1'b0};
   // Mask of column bits that wrap for the programmed length
   assign len_mask = (burst_length_ff == BL_16) ? 4'hf :
                     (burst_length_ff == BL_8) ? 4'h7 : 4'h3;
   assign cur_idx = lnk.burst_start ? 4'h0 : idx_ff;
   assign cur_start = lnk.burst_start ? start_col : start_ff;
   assign cur_mask = lnk.burst_start ? len_mask : mask_ff;
   assign cur_int = lnk.burst_start ?
                    (burst_type_ff && burst_length_ff == BL_8) : mode_int_ff;
   assign cur_nw = lnk.burst_start ?
                   (wrap_control_ff && burst_length_ff == BL_4) : mode_nw_ff;
   assign lo_mask = {{(COL_W-4){1'b0}}, cur_mask};
   assign wide_idx = {{(COL_W-4){1'b0}}, cur_idx};
   // Only length eight interleaves; sixteen and four run sequential
   assign nxt_col = cur_nw ? COL_W'(cur_start + wide_idx) :
                    cur_int ? ((cur_start & ~lo_mask) |
                               ((cur_start ^ wide_idx) & lo_mask)) :
                    ((cur_start & ~lo_mask) |
                     (COL_W'(cur_start + wide_idx) & lo_mask));

   assign wr_burst = lnk.mr_wr && lnk.mr_addr == MA_BURST;
   assign wr_lat = lnk.mr_wr && lnk.mr_addr == MA_LAT;
   // Only 01 to 03 decode as writes, so the status register is untouched
   assign wr_drive = lnk.mr_wr && lnk.mr_addr == MA_DRIVE;
   assign rd_temp = lnk.mr_rd && lnk.mr_addr == MA_TEMP;
   assign wd_low = lnk.mr_wdata[3:0];
   assign lat_new = lat_dec(wd_low);
   assign lat_word = lat_dec(lat_code_ff);
   // A sensor reading of the reserved code is not taken
   assign rate_chg = rate_s2_ff != rate_ff && rate_s2_ff != RATE_RSVD;

   // Burst feature register; no-wrap takes effect only with length four
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         burst_reg_ff <= BURST_RST;
      else if (wr_burst)
         burst_reg_ff <= lnk.mr_wdata;
   end
   assign burst_length_ff = burst_reg_ff[2:0];
   assign burst_type_ff = burst_reg_ff[3];
   assign wrap_control_ff = burst_reg_ff[4];

   // Reserved latency and drive codes leave the setting unchanged
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lat_code_ff <= LAT_RST;
         drive_ff <= DRIVE_RST;
      end
      else
      begin
         if (wr_lat && lat_new[7])
            lat_code_ff <= wd_low;
         if (wr_drive && wd_low != 4'h0 && wd_low != 4'h5 && !wd_low[3])
            drive_ff <= wd_low;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         read_latency_ff <= 4'h3;
         write_latency_ff <= 3'h1;
      end
      else
      begin
         read_latency_ff <= lat_word[7] ? {1'b0, lat_word[6:4]} + 4'h2 :
                            4'h3;
         write_latency_ff <= lat_word[2:0];
      end
   end

   // Sensor code crosses in through two flops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rate_s1_ff <= RATE_RST;
         rate_s2_ff <= RATE_RST;
         rate_ff <= RATE_RST;
      end
      else
      begin
         rate_s1_ff <= temp_rate_in;
         rate_s2_ff <= rate_s1_ff;
         if (rate_chg)
            rate_ff <= rate_s2_ff;
      end
   end

   // Set beats clear so a change during the read is not lost
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flag_ff <= 1'b0;
      else if (rate_chg)
         flag_ff <= 1'b1;
      else if (rd_temp)
         flag_ff <= 1'b0;
   end

   // Write-only and unmapped reads answer zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rvalid_ff <= lnk.mr_rd;
         if (lnk.mr_rd)
            rdata_ff <= rd_temp ? {flag_ff, 4'h0, rate_ff} : 8'h00;
      end
   end

   // Burst sequencer; a new start mid-burst restarts with current mode
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run_ff <= 1'b0;
         idx_ff <= 4'h0;
         mask_ff <= 4'h3;
         mode_int_ff <= 1'b0;
         mode_nw_ff <= 1'b0;
         start_ff <= '0;
         beat_valid_ff <= 1'b0;
         beat_last_ff <= 1'b0;
         beat_write_ff <= 1'b0;
         beat_col_ff <= '0;
      end
      else
      begin
         if (lnk.burst_start)
         begin
            start_ff <= start_col;
            mask_ff <= len_mask;
            mode_int_ff <= cur_int;
            mode_nw_ff <= cur_nw;
            beat_write_ff <= lnk.burst_write;
         end
         beat_valid_ff <= lnk.burst_start || run_ff;
         beat_col_ff <= nxt_col;
         beat_last_ff <= (lnk.burst_start || run_ff) && cur_idx == cur_mask;
         run_ff <= (lnk.burst_start || run_ff) && cur_idx != cur_mask;
         idx_ff <= cur_idx + 4'h1;
      end
   end

   assign lnk.mr_rdata = rdata_ff;
   assign lnk.mr_rvalid = rvalid_ff;
   assign lnk.beat_valid = beat_valid_ff;
   assign lnk.beat_last = beat_last_ff;
   assign lnk.beat_write = beat_write_ff;
   assign lnk.beat_col = beat_col_ff;
   assign read_latency = read_latency_ff;
   assign write_latency = write_latency_ff;
   assign drive_strength_code = drive_ff;
endmodule

// [hdl/sdm_ctrl.sv]
// Memory controller end: AHB-Lite registers drive mode commands and bursts.
// Assumes a single AHB-Lite master and the device on the link.
`timescale 1ns/1ps
module sdm_ctrl
   import sdm_pkg::*;
#(
   parameter bit PART_X32 = 1'b0
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic [3:0] derate_cycles,
   sdm_link_if.ctrl lnk
);
   logic wr_ph_ff;
   logic [7:0] ofs_ff;
   logic [31:0] hrdata_ff;
   logic mr_wr_ff;
   logic mr_rd_ff;
   logic [7:0] mr_addr_ff;
   logic [7:0] mr_wdata_ff;
   logic burst_ff;
   logic burst_wr_ff;
   logic [COL_W-1:1] col_ff;
   logic [7:0] shadow_ff;
   logic busy_ff;
   logic err_ff;
   logic derate_ff;
   logic rvalid_ff;
   logic [7:0] rd_ff;
   logic [7:0] rd_addr_ff;
   logic [3:0] derate_cyc_ff;
   logic take;
   logic do_mrw;
   logic do_mrr;
   logic do_burst;
   logic do_stat;
   logic [7:0] w_addr;
   logic [7:0] w_data;
   logic [7:0] w_clean;
   logic bad_mrw;
   logic bad_burst;
   logic [COL_W-1:0] y_col;
   logic sh_nw;
   logic [31:0] status_word;

   assign take = hsel && htrans[1] && hready;
   assign do_mrw = wr_ph_ff && ofs_ff == OFS_MRW;
   assign do_mrr = wr_ph_ff && ofs_ff == OFS_MRR;
   assign do_burst = wr_ph_ff && ofs_ff == OFS_BURST;
   assign do_stat = wr_ph_ff && ofs_ff == OFS_STATUS;
   assign w_addr = hwdata[15:8];
   assign w_data = hwdata[7:0];
   // Unused bits of the narrow registers go out as zero
   assign w_clean = (w_addr == MA_LAT || w_addr == MA_DRIVE) ?
                    (w_data & LOW_MASK) : w_data;
   assign bad_mrw = w_addr == MA_TEMP ||
      (w_addr == MA_LAT && (w_clean[3:0] == 4'h0 ||
                            w_clean[3:0] > 4'h6)) ||
      (w_addr == MA_BURST && w_data[2:0] == BL_16 && w_data[3]) ||
      (w_addr == MA_BURST && w_data[4] && w_data[2:0] != BL_4);
   assign y_col = {hwdata[COL_W-1:1], 1'b0};
   assign sh_nw = shadow_ff[4] && shadow_ff[2:0] == BL_4;
   // Boundary-crossing no-wrap starts are refused before reaching the link
   assign bad_burst = busy_ff || (sh_nw && (PART_X32 ?
                      y_col == {1'b0, NW_BAD_COL} :
                      y_col[8:0] == NW_BAD_COL));
   assign status_word = {16'h0000, rd_ff, 4'h0, rvalid_ff, derate_ff,
                         err_ff, busy_ff};

   // Address phase; reads are answered from a register in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ph_ff <= 1'b0;
         ofs_ff <= 8'h00;
         hrdata_ff <= 32'h0000_0000;
      end
      else
      begin
         wr_ph_ff <= take && hwrite;
         if (take)
            ofs_ff <= haddr[7:0];
         if (take && !hwrite)
            hrdata_ff <= haddr[7:0] == OFS_STATUS ? status_word :
                         32'h0000_0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mr_wr_ff <= 1'b0;
         mr_rd_ff <= 1'b0;
         mr_addr_ff <= 8'h00;
         mr_wdata_ff <= 8'h00;
         burst_ff <= 1'b0;
         burst_wr_ff <= 1'b0;
         col_ff <= '0;
         shadow_ff <= BURST_RST;
      end
      else
      begin
         mr_wr_ff <= do_mrw && !bad_mrw;
         mr_rd_ff <= do_mrr;
         burst_ff <= do_burst && !bad_burst;
         if ((do_mrw && !bad_mrw) || do_mrr)
            mr_addr_ff <= do_mrr ? w_data : w_addr;
         if (do_mrw && !bad_mrw)
            mr_wdata_ff <= w_clean;
         if (do_mrw && !bad_mrw && w_addr == MA_BURST)
            shadow_ff <= w_data;
         if (do_burst && !bad_burst)
         begin
            col_ff <= hwdata[COL_W-1:1];
            burst_wr_ff <= hwdata[BURST_WR_BIT];
         end
      end
   end

   // Error is set over a write-one clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         busy_ff <= 1'b0;
         err_ff <= 1'b0;
         derate_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rd_ff <= 8'h00;
         rd_addr_ff <= 8'h00;
         derate_cyc_ff <= 4'h0;
      end
      else
      begin
         if (do_burst && !bad_burst)
            busy_ff <= 1'b1;
         else if (lnk.beat_valid && lnk.beat_last)
            busy_ff <= 1'b0;
         if ((do_mrw && bad_mrw) || (do_burst && bad_burst))
            err_ff <= 1'b1;
         else if (do_stat && hwdata[ST_ERR])
            err_ff <= 1'b0;
         if (do_mrr)
         begin
            rd_addr_ff <= w_data;
            rvalid_ff <= 1'b0;
         end
         else if (lnk.mr_rvalid)
         begin
            rvalid_ff <= 1'b1;
            rd_ff <= lnk.mr_rdata;
            if (rd_addr_ff == MA_TEMP)
               derate_ff <= lnk.mr_rdata[2:0] == RATE_DERATE;
         end
         derate_cyc_ff <= derate_ff ? DERATE_CYC : 4'h0;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;
   assign derate_cycles = derate_cyc_ff;
   assign lnk.mr_wr = mr_wr_ff;
   assign lnk.mr_rd = mr_rd_ff;
   assign lnk.mr_addr = mr_addr_ff;
   assign lnk.mr_wdata = mr_wdata_ff;
   assign lnk.burst_start = burst_ff;
   assign lnk.burst_write = burst_wr_ff;
   assign lnk.burst_col = col_ff;
endmodule

// [verif/sdm_link_sva.sv]
// Checker for the link between the controller and the mode logic.
// Assumes one clock and the active low reset shared by both ends.
`timescale 1ns/1ps
module sdm_link_sva
   import sdm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic mr_wr,
   input wire logic mr_rd,
   input wire logic [7:0] mr_addr,
   input wire logic [7:0] mr_wdata,
   input wire logic [7:0] mr_rdata,
   input wire logic mr_rvalid,
   input wire logic burst_start,
   input wire logic burst_write,
   input wire logic [COL_W-1:1] burst_col,
   input wire logic beat_valid,
   input wire logic beat_last,
   input wire logic beat_write,
   input wire logic [COL_W-1:0] beat_col
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire burst_mrw = mr_wr && mr_addr == MA_BURST;
   sequence end4_s;
      beat_valid [*4] ##0 beat_last;
   endsequence
   sequence end8_s;
      beat_valid [*8] ##0 beat_last;
   endsequence
   // Sixteen beats split in two runs to keep the repetition short
   sequence end16_s;
      beat_valid [*8] ##1 beat_valid [*8] ##0 beat_last;
   endsequence
   burst_len_a: assert property (burst_start |=>
      (end4_s or end8_s or end16_s)) else $error("burst length wrong");
   first_beat_a: assert property (burst_start |=> beat_valid &&
      beat_col == {$past(burst_col), 1'b0} &&
      beat_write == $past(burst_write)) else $error("first beat wrong");
   // Even start means every order alternates even and odd columns
   beat_parity_a: assert property (beat_valid && !beat_last &&
      !burst_start |=> beat_valid && beat_col[0] != $past(beat_col[0]))
      else $error("beat column parity wrong");
   rd_answer_a: assert property (mr_rd |=> mr_rvalid)
      else $error("mode read not answered");
   rvalid_cause_a: assert property (mr_rvalid |-> $past(mr_rd))
      else $error("stray read answer");
   temp_rsvd_a: assert property (mr_rvalid && $past(mr_addr) == MA_TEMP
      |-> mr_rdata[6:3] == 4'h0 && mr_rdata[2:0] != RATE_RSVD)
      else $error("temperature read bad bits");
   other_zero_a: assert property (mr_rvalid &&
      $past(mr_addr) != MA_TEMP |-> mr_rdata == 8'h00)
      else $error("write-only read not zero");
   ro_write_a: assert property (mr_wr |-> mr_addr != MA_TEMP)
      else $error("write to read-only register");
   lat_code_a: assert property (mr_wr && mr_addr == MA_LAT |->
      mr_wdata inside {[8'h01:8'h06]}) else $error("reserved latency sent");
   bl16_seq_a: assert property (burst_mrw && mr_wdata[2:0] == BL_16
      |-> mr_wdata[4:3] == 2'h0) else $error("length sixteen not seq wrap");
   nw_bl4_a: assert property (burst_mrw && mr_wdata[4] |->
      mr_wdata[2:0] == BL_4) else $error("no-wrap without length four");
endmodule

// [verif/testbench.sv]
// Bench for the mode register logic and its AHB-Lite controller.
// Assumes a zero wait state slave and the x16 part.
`timescale 1ns/1ps
module testbench
   import sdm_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [2:0] temp_rate = 3'h3;
   wire hready;
   wire hresp;
   wire [31:0] hrdata;
   wire [3:0] derate_cycles;
   wire [3:0] read_latency;
   wire [2:0] write_latency;
   wire [3:0] drive;
   logic [31:0] rd;
   logic [9:0] beats[$];
   int error_cnt = 0;
   int total_checks = 0;
   logic [3:0] rl_tab [6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
   logic [2:0] wl_tab [6] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4};
   logic [3:0] ds_tab [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
   logic [2:0] rt_tab [7] = '{3'h2, 3'h1, 3'h5, 3'h6, 3'h7, 3'h0, 3'h3};
   logic [7:0] cf_tab [9] = '{8'h02, 8'h03, 8'h0b, 8'h04, 8'h12, 8'h12,
      8'h12, 8'h0c, 8'h13};
   logic [9:0] cl_tab [9] = '{10'h006, 10'h00c, 10'h00a, 10'h01e, 10'h0fe,
      10'h1fe, 10'h3fe, 10'h010, 10'h022};
   sdm_link_if sdm_link_if_i ();
   sdm_ctrl #(.PART_X32(1'b0)) sdm_ctrl_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .derate_cycles(derate_cycles),
      .lnk(sdm_link_if_i.ctrl));
   sdm_device sdm_device_i (.hclk(hclk), .hresetn(hresetn),
      .lnk(sdm_link_if_i.device), .temp_rate_in(temp_rate),
      .read_latency(read_latency), .write_latency(write_latency),
      .drive_strength_code(drive));
   sdm_link_sva sdm_link_sva_i (.hclk(hclk), .hresetn(hresetn),
      .mr_wr(sdm_link_if_i.mr_wr), .mr_rd(sdm_link_if_i.mr_rd),
      .mr_addr(sdm_link_if_i.mr_addr), .mr_wdata(sdm_link_if_i.mr_wdata),
      .mr_rdata(sdm_link_if_i.mr_rdata), .mr_rvalid(sdm_link_if_i.mr_rvalid),
      .burst_start(sdm_link_if_i.burst_start),
      .burst_write(sdm_link_if_i.burst_write),
      .burst_col(sdm_link_if_i.burst_col),
      .beat_valid(sdm_link_if_i.beat_valid),
      .beat_last(sdm_link_if_i.beat_last),
      .beat_write(sdm_link_if_i.beat_write),
      .beat_col(sdm_link_if_i.beat_col));
   always #5 hclk = ~hclk;
   // Sampled on the falling edge so beats are settled
   always @(negedge hclk)
      if (sdm_link_if_i.beat_valid === 1'b1)
         beats.push_back(sdm_link_if_i.beat_col);
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
      total_checks++;
      if (got !== ex)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            error_cnt++;
            $display("ERROR hready expected 1 seen %b", hready);
            end_sim;
         end
         @(posedge hclk);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= 32'(a);
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rdreg(input logic [7:0] a);
      ahb(1'b0, a, 32'h0);
   endtask
   task automatic mrw(input logic [7:0] a, input logic [7:0] v);
      wr(OFS_MRW, {16'h0000, a, v});
      repeat (4) @(posedge hclk);
   endtask
   task automatic mrd(input logic [7:0] a = MA_TEMP);
      wr(OFS_MRR, 32'(a));
      repeat (4) @(posedge hclk);
      rdreg(OFS_STATUS);
   endtask
   function automatic logic legal(input logic [7:0] c);
      return c[2:0] inside {BL_4, BL_8, BL_16} &&
         !(c[2:0] == BL_16 && c[3]) && !(c[4] && c[2:0] != BL_4);
   endfunction
   initial
   begin
      logic [7:0] cur;
      logic ok;
      logic bad;
      int len;
      int ex;
      cur = 8'h22;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("read_latency", 32'h3, 32'(read_latency));
      chk("write_latency", 32'h1, 32'(write_latency));
      chk("drive", 32'h2, 32'(drive));
      mrd();
      chk("temp_status", 32'h3, 32'(rd[15:8]));
      mrd(MA_LAT);
      chk("wo_read", 32'h0, 32'(rd[15:8]));
      chk("hresp", 32'h0, 32'(hresp));
      wr(8'h20, 32'h5a5a_5a5a);
      rdreg(8'h20);
      chk("unmapped", 32'h0, rd);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         mrw(MA_LAT, 8'(i + 1));
         chk("read_latency", 32'(rl_tab[i]), 32'(read_latency));
         chk("write_latency", 32'(wl_tab[i]), 32'(write_latency));
         mrw(MA_DRIVE, 8'(ds_tab[i]));
         chk("drive", 32'(ds_tab[i]), 32'(drive));
      end
      mrw(MA_LAT, 8'h07);
      chk("read_latency", 32'h8, 32'(read_latency));
      mrw(MA_DRIVE, 8'h05);
      mrw(MA_DRIVE, 8'h08);
      chk("drive", 32'h7, 32'(drive));
      rdreg(OFS_STATUS);
      chk("status_err", 32'h1, 32'(rd[ST_ERR]));
      wr(OFS_STATUS, 32'h2);
      $display("test latency and drive done");
      for (int i = 0; i < 7; i++)
      begin
         temp_rate <= rt_tab[i];
         repeat (6) @(posedge hclk);
         mrd();
         chk("flag_set", 32'({1'b1, 4'h0, rt_tab[i]}), 32'(rd[15:8]));
         mrd();
         chk("flag_clr", 32'({1'b0, 4'h0, rt_tab[i]}), 32'(rd[15:8]));
         chk("derate", rt_tab[i] == 3'h6, 32'(rd[ST_DERATE]));
         chk("derate_cycles", rt_tab[i] == 3'h6, 32'(derate_cycles));
      end
      temp_rate <= 3'h4;
      repeat (6) @(posedge hclk);
      mrd();
      chk("temp_rsvd", 32'h3, 32'(rd[15:8]));
      mrw(MA_TEMP, 8'h81);
      mrd();
      chk("temp_ro", 32'h3, 32'(rd[15:8]));
      chk("status_err", 32'h1, 32'(rd[ST_ERR]));
      wr(OFS_STATUS, 32'h2);
      $display("test temperature done");
      for (int i = 0; i < 9; i++)
      begin
         ok = legal(cf_tab[i]);
         mrw(MA_BURST, cf_tab[i]);
         if (ok)
            cur = cf_tab[i];
         bad = cur[4] && (cl_tab[i] == 10'h3fe || cl_tab[i] == 10'h1fe);
         len = 4 << (cur[2:0] - 3'h2);
         beats.delete();
         wr(OFS_BURST, {15'h0000, i[0], 6'h00, cl_tab[i]});
         repeat (20) @(posedge hclk);
         chk("beat_count", bad ? 0 : len, beats.size());
         for (int j = 0; j < beats.size() && j < len; j++)
         begin
            if (cur[4])
               ex = cl_tab[i] + j;
            else if (cur[3])
               ex = (cl_tab[i] & ~(len - 1)) | ((cl_tab[i] ^ j) & (len - 1));
            else
               ex = (cl_tab[i] & ~(len - 1)) | ((cl_tab[i] + j) & (len - 1));
            chk("beat_col", ex, 32'(beats[j]));
         end
         rdreg(OFS_STATUS);
         chk("status_err", !ok || bad, 32'(rd[ST_ERR]));
         wr(OFS_STATUS, 32'h2);
      end
      $display("test bursts done");
      end_sim;
   end
endmodule
